// *** bench/tb_top.sv ***
// Self-checking bench for the twelve line parallel I/O port.
// Assumes the pin model resolves the wire level from the port and the far-side driver.
`timescale 1ns/100ps

module tb_top
  import tlpio_pkg::*;
;
  logic             clk_sys;
  logic             srst;
  tlpio_req_type    req;
  tlpio_resp_type   resp;
  logic             refresh;
  logic [11:0]      pin_in;
  logic [11:0]      pin_out;
  logic [11:0]      pin_oe;
  logic             drive_high_current;
  logic [11:0]      ext_en;
  logic [11:0]      ext_val;
  int               num_errors;
  int               check_count;

  tlpio_port dut (.clk_sys(clk_sys), .srst(srst), .req(req), .resp(resp), .refresh(refresh),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .drive_high_current(drive_high_current));
  tlpio_pin_model far_side (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk_sys);
    req.wr    <= 1'b0;
  endtask
  // Read answer stands one cycle, so sample just after the taking edge
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_sys);
    req.rd   <= 1'b0;
    #1;
    chk({3'h0, resp.rvalid, resp.rdata}, {4'h1, exp});
  endtask
  task automatic pins_chk(input logic [11:0] exp);
    rd_chk(ADDR_PIN_LO, exp[7:0]);
    rd_chk(ADDR_PIN_HI, {4'h0, exp[11:8]});
  endtask
  // Sequential mode may need twelve steps, each setting one line's oe and level together
  task automatic settle();
    repeat (30) @(posedge clk_sys);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    rd_chk(ADDR_DEF_OUT_LO, 8'hFF);
    rd_chk(ADDR_DEF_OUT_HI, 8'h0F);
    rd_chk(ADDR_DEF_CFG, 8'h80);
    rd_chk(ADDR_OUT_LO, 8'hFF);
    rd_chk(ADDR_OUT_HI, 8'h0F);
    rd_chk(ADDR_DIR_LO, 8'hFF);
    rd_chk(ADDR_DIR_HI, 8'h0F);
    rd_chk(ADDR_INV_LO, 8'h00);
    rd_chk(ADDR_CFG, 8'h80);
    chk(pin_oe, 12'h000);
    chk({11'h0, drive_high_current}, 12'h001);
    pins_chk(12'hFFF);
  endtask
  task automatic t_push_pull();
    wr(ADDR_CFG, 8'h00);
    wr(ADDR_DIR_LO, 8'h00);
    wr(ADDR_DIR_HI, 8'hF0);
    wr(ADDR_OUT_LO, 8'hA5);
    wr(ADDR_OUT_HI, 8'hFA);
    settle();
    rd_chk(ADDR_OUT_HI, 8'h0A);
    rd_chk(ADDR_DIR_HI, 8'h00);
    chk(pin_oe, 12'hFFF);
    chk(pin_out, 12'hAA5);
    chk({11'h0, drive_high_current}, 12'h000);
    pins_chk(12'hAA5);
  endtask
  task automatic t_invert();
    wr(ADDR_INV_LO, 8'hFF);
    wr(ADDR_CFG, 8'h0F);
    settle();
    pins_chk(12'h55A);
    wr(ADDR_INV_LO, 8'h00);
  endtask
  // Middle group open drain first, then all three groups: their high lines are released
  task automatic t_open_drain();
    wr(ADDR_CFG, 8'h20);
    settle();
    chk(pin_oe, 12'hF5F);
    chk(pin_out, 12'hA05);
    wr(ADDR_CFG, 8'h70);
    ext_en  <= 12'hFFF;
    ext_val <= 12'h000;
    settle();
    chk(pin_oe, 12'h55A);
    chk(pin_out, 12'h000);
    pins_chk(12'h000);
  endtask
  task automatic t_input();
    wr(ADDR_DIR_LO, 8'hFF);
    wr(ADDR_DIR_HI, 8'h0F);
    ext_val <= 12'h3C6;
    settle();
    chk(pin_oe, 12'h000);
    pins_chk(12'h3C6);
    wr(ADDR_PIN_LO, 8'h12);
    wr(ADDR_PIN_HI, 8'h34);
    pins_chk(12'h3C6);
  endtask
  task automatic t_sequential();
    ext_en <= 12'h000;
    wr(ADDR_CFG, 8'h80);
    wr(ADDR_DIR_LO, 8'h00);
    wr(ADDR_DIR_HI, 8'h00);
    wr(ADDR_OUT_LO, 8'h00);
    wr(ADDR_OUT_HI, 8'h00);
    settle();
    chk({11'h0, drive_high_current}, 12'h001);
    chk(pin_oe, 12'hFFF);
    wr(ADDR_OUT_LO, 8'hFF);
    repeat (2) @(posedge clk_sys);
    #1;
    chk({11'h0, $countones(pin_out) < 8}, 12'h001);
    settle();
    chk(pin_out, 12'h0FF);
  endtask
  task automatic t_refresh();
    wr(ADDR_DEF_OUT_LO, 8'h3C);
    wr(ADDR_DEF_OUT_HI, 8'h05);
    wr(ADDR_DEF_DIR_LO, 8'h00);
    wr(ADDR_DEF_DIR_HI, 8'h00);
    wr(ADDR_DEF_CFG, 8'h00);
    @(posedge clk_sys);
    refresh <= 1'b1;
    @(posedge clk_sys);
    refresh <= 1'b0;
    settle();
    rd_chk(ADDR_OUT_LO, 8'h3C);
    rd_chk(ADDR_OUT_HI, 8'h05);
    rd_chk(ADDR_DIR_LO, 8'h00);
    rd_chk(ADDR_CFG, 8'h00);
    chk(pin_out, 12'h53C);
  endtask

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Whole sequence needs well under 1000 cycles
  initial
  begin
    #500us;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    num_errors  = 0;
    check_count = 0;
    srst        = 1'b1;
    req         = '0;
    refresh     = 1'b0;
    ext_en      = 12'h000;
    ext_val     = 12'h000;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_push_pull();
    t_invert();
    t_open_drain();
    t_input();
    t_sequential();
    t_refresh();
    wrap_up();
  end
endmodule

// *** bench/tlpio_pin_model.sv ***
// External circuitry on the twelve port lines: pull-ups plus a bench-controlled driver.
// Assumes the port's drive outputs are registered on clk_sys.
`timescale 1ns/100ps

module tlpio_pin_model
  import tlpio_pkg::*;
(
  // From the port
  input  wire logic [TLPIO_LINES-1:0] pin_out,
  input  wire logic [TLPIO_LINES-1:0] pin_oe,
  // Far-side driver
  input  wire logic [TLPIO_LINES-1:0] ext_en,
  input  wire logic [TLPIO_LINES-1:0] ext_val,
  // Resolved wire level
  output logic      [TLPIO_LINES-1:0] pin_in
);
  // The port driver wins; a released line with no far driver floats up on its pull-up
  always_comb
  begin
    for (int i = 0; i < TLPIO_LINES; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else
        pin_in[i] = 1'b1;
    end
  end
endmodule

// *** include/tlpio_pkg.sv ***
// Package for the twelve line parallel I/O port: register map, reset values and carriers.
// Assumes byte-wide register access on a 9-bit address, one clock domain.
package tlpio_pkg;

  // --------------------------------------------------------------------------
  // Sizes and field positions
  // --------------------------------------------------------------------------
  localparam int          TLPIO_LINES       = 12;
  localparam int          TLPIO_GROUP_LINES = 4;
  localparam int          TLPIO_GROUPS      = 3;
  localparam int          CFG_INV_MSB       = 3;
  localparam int          CFG_TYPE_LSB      = 4;
  localparam int          CFG_MODE_BIT      = 7;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [8:0]  ADDR_DEF_OUT_LO   = 9'h10A;
  localparam logic [8:0]  ADDR_DEF_OUT_HI   = 9'h10B;
  localparam logic [8:0]  ADDR_DEF_DIR_LO   = 9'h10C;
  localparam logic [8:0]  ADDR_DEF_DIR_HI   = 9'h10D;
  localparam logic [8:0]  ADDR_DEF_INV_LO   = 9'h10E;
  localparam logic [8:0]  ADDR_DEF_CFG      = 9'h10F;
  localparam logic [8:0]  ADDR_OUT_LO       = 9'h120;
  localparam logic [8:0]  ADDR_OUT_HI       = 9'h121;
  localparam logic [8:0]  ADDR_DIR_LO       = 9'h122;
  localparam logic [8:0]  ADDR_DIR_HI       = 9'h123;
  localparam logic [8:0]  ADDR_INV_LO       = 9'h124;
  localparam logic [8:0]  ADDR_CFG          = 9'h125;
  localparam logic [8:0]  ADDR_PIN_LO       = 9'h126;
  localparam logic [8:0]  ADDR_PIN_HI       = 9'h127;

  // --------------------------------------------------------------------------
  // Factory values of the nonvolatile defaults
  // --------------------------------------------------------------------------
  localparam logic [11:0] DEF_OUT_RST       = 12'hFFF;
  localparam logic [11:0] DEF_DIR_RST       = 12'hFFF;
  localparam logic [7:0]  DEF_INV_LO_RST    = 8'h00;
  localparam logic [7:0]  DEF_CFG_RST       = 8'h80;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tlpio_req_type;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } tlpio_resp_type;

  typedef struct packed {
    logic [11:0] level;
    logic [11:0] oe;
  } tlpio_drive_type;

  typedef struct packed {
    logic [11:0]     def_out;
    logic [11:0]     def_dir;
    logic [7:0]      def_inv_lo;
    logic [7:0]      def_cfg;
    logic [11:0]     out_value;
    logic [11:0]     direction;
    logic [11:0]     invert;
    logic [2:0]      drive_type;
    logic            drive_strength_select;
    logic [11:0]     pin_sample;
    tlpio_drive_type drive;
    tlpio_resp_type  resp;
  } tlpio_state_type;

endpackage

// *** logic/tlpio_port.sv ***
// Twelve line parallel I/O port: live settings, nonvolatile defaults, pin drive and pin readback.
// Assumes a byte register port already decoded from the serial host, pins synchronous to clk_sys.
//
// Functional notes
// [RL1] Output value bit n drives line n low or high when the line is an output.
// [RL2] Power-up copies default output values into the output value registers.
// [RL3] Direction bit 0 makes a line output, 1 makes it input.
// [RL4] Power-up loads direction registers from default direction registers.
// [RL5] Inversion register holds read inversion for lines 0-7, loaded at power-up.
// [RL6] Configuration bits 0-3 invert lines 8-11; whole register loaded at power-up.
// [RL7] Configuration bits 4-6 pick push-pull or open drain per group of four.
// [RL8] Configuration bit 7: low-current simultaneous or high-current sequential switching.
// [RL9] Pin-state registers are read-only; writes do nothing.
// [RL10] Upper four bits of the second pin-state register read zero.
// [RL11] Pin-state reads work for any direction and show the real pin level.
// [RL12] Pin-state bit equals pin level XOR the line's inversion bit.
// [RL13] Input lines have their driver switched off.
// [RL14] Output lines read back output value XOR inversion bit; released open-drain lines read the sampled pin instead.
// [RL15] Power-up and refresh reload all live settings from the defaults.
// [RL16] Default output values ship with every implemented bit set.
// [RL17] Default configuration ships with only the mode bit set.
// [RL18] Unused upper bits of second output and direction registers ignore writes, read zero.
`timescale 1ns/100ps

module tlpio_port
  import tlpio_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  // Register port
  input  wire tlpio_req_type          req,
  output tlpio_resp_type              resp,
  // Refresh event from the serial interface
  input  wire logic                   refresh,
  // Pins
  input  wire logic [TLPIO_LINES-1:0] pin_in,
  output logic      [TLPIO_LINES-1:0] pin_out,
  output logic      [TLPIO_LINES-1:0] pin_oe,
  output logic                        drive_high_current
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic int line_group(input int line);
    line_group = line / TLPIO_GROUP_LINES;
  endfunction

  function automatic logic addr_is(input logic [8:0] a, input logic [8:0] ref_addr);
    addr_is = (a == ref_addr);
  endfunction

  tlpio_state_type             st;
  tlpio_state_type             next_st;
  logic [TLPIO_LINES-1:0]      target_level;
  logic [TLPIO_LINES-1:0]      target_oe;
  logic [TLPIO_LINES-1:0]      pin_level;
  logic [TLPIO_LINES-1:0]      pin_state;

  // --------------------------------------------------------------------------
  // Per-line drive target and readback
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < TLPIO_LINES; gi++)
    begin : g_line
      // Open drain never drives high; a released line reads whatever the outside pulls it to
      assign target_oe[gi]    = ~st.direction[gi] & (~st.drive_type[line_group(gi)] | ~st.out_value[gi]); // [RL13] [RL7]
      assign target_level[gi] = st.out_value[gi] & ~st.drive_type[line_group(gi)]; // [RL1] [RL3]
      // Driven lines read what we drive, others the sampled pin
      assign pin_level[gi]    = st.drive.oe[gi] ? st.drive.level[gi] : st.pin_sample[gi]; // [RL11] [RL14]
      assign pin_state[gi]    = pin_level[gi] ^ st.invert[gi]; // [RL12]
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic found;
    found = 1'b0;
    next_st = st;
    next_st.pin_sample = pin_in;
    next_st.resp.rvalid = req.rd;
    next_st.resp.rdata = 8'h00;

    // Sequential mode moves one line per clock to limit supply surge at high current
    if (st.drive_strength_select) // [RL8]
    begin
      for (int i = 0; i < TLPIO_LINES; i++)
      begin
        if (!found && (st.drive.oe[i] != target_oe[i] || st.drive.level[i] != target_level[i]))
        begin
          found = 1'b1;
          next_st.drive.oe[i] = target_oe[i];
          next_st.drive.level[i] = target_level[i];
        end
      end
    end
    else
    begin
      next_st.drive.oe = target_oe;
      next_st.drive.level = target_level;
    end

    // Register writes; pin-state addresses fall through untouched
    if (req.wr) // [RL9]
    begin
      if (addr_is(req.addr, ADDR_DEF_OUT_LO))
        next_st.def_out[7:0] = req.wdata;
      else if (addr_is(req.addr, ADDR_DEF_OUT_HI))
        next_st.def_out[11:8] = req.wdata[3:0];
      else if (addr_is(req.addr, ADDR_DEF_DIR_LO))
        next_st.def_dir[7:0] = req.wdata;
      else if (addr_is(req.addr, ADDR_DEF_DIR_HI))
        next_st.def_dir[11:8] = req.wdata[3:0];
      else if (addr_is(req.addr, ADDR_DEF_INV_LO))
        next_st.def_inv_lo = req.wdata;
      else if (addr_is(req.addr, ADDR_DEF_CFG))
        next_st.def_cfg = req.wdata;
      else if (addr_is(req.addr, ADDR_OUT_LO))
        next_st.out_value[7:0] = req.wdata; // [RL1]
      else if (addr_is(req.addr, ADDR_OUT_HI))
        next_st.out_value[11:8] = req.wdata[3:0]; // [RL1] [RL18]
      else if (addr_is(req.addr, ADDR_DIR_LO))
        next_st.direction[7:0] = req.wdata; // [RL3]
      else if (addr_is(req.addr, ADDR_DIR_HI))
        next_st.direction[11:8] = req.wdata[3:0]; // [RL3] [RL18]
      else if (addr_is(req.addr, ADDR_INV_LO))
        next_st.invert[7:0] = req.wdata; // [RL5]
      else if (addr_is(req.addr, ADDR_CFG))
      begin
        next_st.invert[11:8] = req.wdata[CFG_INV_MSB:0]; // [RL6]
        next_st.drive_type = req.wdata[CFG_MODE_BIT-1:CFG_TYPE_LSB]; // [RL7]
        next_st.drive_strength_select = req.wdata[CFG_MODE_BIT]; // [RL8]
      end
    end

    // Refresh overrides a write to the live settings in the same cycle
    if (refresh) // [RL15]
    begin
      next_st.out_value = st.def_out;
      next_st.direction = st.def_dir;
      next_st.invert = {st.def_cfg[CFG_INV_MSB:0], st.def_inv_lo};
      next_st.drive_type = st.def_cfg[CFG_MODE_BIT-1:CFG_TYPE_LSB];
      next_st.drive_strength_select = st.def_cfg[CFG_MODE_BIT];
    end

    // Register reads
    if (req.rd)
    begin
      if (addr_is(req.addr, ADDR_DEF_OUT_LO))
        next_st.resp.rdata = st.def_out[7:0];
      else if (addr_is(req.addr, ADDR_DEF_OUT_HI))
        next_st.resp.rdata = {4'h0, st.def_out[11:8]};
      else if (addr_is(req.addr, ADDR_DEF_DIR_LO))
        next_st.resp.rdata = st.def_dir[7:0];
      else if (addr_is(req.addr, ADDR_DEF_DIR_HI))
        next_st.resp.rdata = {4'h0, st.def_dir[11:8]};
      else if (addr_is(req.addr, ADDR_DEF_INV_LO))
        next_st.resp.rdata = st.def_inv_lo;
      else if (addr_is(req.addr, ADDR_DEF_CFG))
        next_st.resp.rdata = st.def_cfg;
      else if (addr_is(req.addr, ADDR_OUT_LO))
        next_st.resp.rdata = st.out_value[7:0];
      else if (addr_is(req.addr, ADDR_OUT_HI))
        next_st.resp.rdata = {4'h0, st.out_value[11:8]}; // [RL18]
      else if (addr_is(req.addr, ADDR_DIR_LO))
        next_st.resp.rdata = st.direction[7:0];
      else if (addr_is(req.addr, ADDR_DIR_HI))
        next_st.resp.rdata = {4'h0, st.direction[11:8]}; // [RL18]
      else if (addr_is(req.addr, ADDR_INV_LO))
        next_st.resp.rdata = st.invert[7:0];
      else if (addr_is(req.addr, ADDR_CFG))
        next_st.resp.rdata = {st.drive_strength_select, st.drive_type, st.invert[11:8]};
      else if (addr_is(req.addr, ADDR_PIN_LO))
        next_st.resp.rdata = pin_state[7:0]; // [RL11]
      else if (addr_is(req.addr, ADDR_PIN_HI))
        next_st.resp.rdata = {4'h0, pin_state[11:8]}; // [RL10]
    end
  end

  // --------------------------------------------------------------------------
  // State register; reset acts as power-up
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st <= '0;
      st.def_out <= DEF_OUT_RST; // [RL16]
      st.def_dir <= DEF_DIR_RST;
      st.def_inv_lo <= DEF_INV_LO_RST;
      st.def_cfg <= DEF_CFG_RST; // [RL17]
      st.out_value <= DEF_OUT_RST; // [RL2] [RL15]
      st.direction <= DEF_DIR_RST; // [RL4]
      st.invert <= {DEF_CFG_RST[CFG_INV_MSB:0], DEF_INV_LO_RST}; // [RL5] [RL6]
      st.drive_type <= DEF_CFG_RST[CFG_MODE_BIT-1:CFG_TYPE_LSB];
      st.drive_strength_select <= DEF_CFG_RST[CFG_MODE_BIT];
    end
    else
      st <= next_st;
  end

  assign resp               = st.resp;
  assign pin_out            = st.drive.level;
  assign pin_oe             = st.drive.oe;
  assign drive_high_current = st.drive_strength_select;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  read_answer_a: assert property (req.rd |=> resp.rvalid) // [RL11]
    else $error("Read not answered next cycle");

  pin_state_ro_a: assert property (req.wr && req.addr == ADDR_PIN_LO && !refresh
                                   |=> $stable(st.out_value) && $stable(st.direction) && $stable(st.invert)) // [RL9]
    else $error("Write to pin state changed settings");

  pin_high_zero_a: assert property (req.rd && req.addr == ADDR_PIN_HI |=> resp.rdata[7:4] == 4'h0) // [RL10]
    else $error("Pin state upper bits not zero");

  pin_xor_a: assert property (req.rd && req.addr == ADDR_PIN_LO && st.drive.oe[7:0] == 8'h00
                              |=> resp.rdata == $past(st.pin_sample[7:0] ^ st.invert[7:0])) // [RL12]
    else $error("Pin state is not pin XOR inversion");

  input_hiz_a: assert property (!st.drive_strength_select |=> (st.drive.oe & $past(st.direction)) == 12'h000) // [RL13]
    else $error("Input line still driven");

  push_pull_a: assert property (!st.drive_strength_select && !st.drive_type[0]
                                |=> (st.drive.level[3:0] | $past(st.direction[3:0]))
                                    == ($past(st.out_value[3:0]) | $past(st.direction[3:0]))) // [RL1]
    else $error("Push-pull level differs from output value");

  open_drain_a: assert property (!st.drive_strength_select && st.drive_type[1] |=> st.drive.level[7:4] == 4'h0) // [RL7]
    else $error("Open drain group driven high");

  seq_switch_a: assert property (st.drive_strength_select
                                 |=> $countones(($past(st.drive.oe) ^ st.drive.oe)
                                                | ($past(st.drive.level) ^ st.drive.level)) <= 1) // [RL8]
    else $error("More than one line switched in sequential mode");

  refresh_load_a: assert property (refresh |=> st.out_value == $past(st.def_out)
                                   && st.direction == $past(st.def_dir)) // [RL15]
    else $error("Refresh did not reload settings");

  invert_write_a: assert property (req.wr && req.addr == ADDR_INV_LO && !refresh
                                   |=> st.invert[7:0] == $past(req.wdata)) // [RL5]
    else $error("Inversion write lost");

  // Answer lines must sit at zero between reads so a host can OR several ports together
  idle_no_answer_a: assert property (!req.rd |=> !resp.rvalid && resp.rdata == 8'h00) // [RL11]
    else $error("Answer without a read");

  out_lo_write_a: assert property (req.wr && req.addr == ADDR_OUT_LO && !refresh
                                   |=> st.out_value[7:0] == $past(req.wdata)) // [RL1]
    else $error("Output value write lost");

  out_hi_write_a: assert property (req.wr && req.addr == ADDR_OUT_HI && !refresh
                                   |=> st.out_value[11:8] == $past(req.wdata[3:0])) // [RL18]
    else $error("Upper output value write wrong");

  dir_lo_write_a: assert property (req.wr && req.addr == ADDR_DIR_LO && !refresh
                                   |=> st.direction[7:0] == $past(req.wdata)) // [RL3]
    else $error("Direction write lost");

  dir_hi_write_a: assert property (req.wr && req.addr == ADDR_DIR_HI && !refresh
                                   |=> st.direction[11:8] == $past(req.wdata[3:0])) // [RL18]
    else $error("Upper direction write wrong");

  cfg_write_a: assert property (req.wr && req.addr == ADDR_CFG && !refresh
                                |=> {st.drive_strength_select, st.drive_type, st.invert[11:8]}
                                    == $past(req.wdata)) // [RL6]
    else $error("Configuration write lost");

  def_out_write_a: assert property (req.wr && req.addr == ADDR_DEF_OUT_LO
                                    |=> st.def_out[7:0] == $past(req.wdata)) // [RL2]
    else $error("Default output write lost");

  def_dir_write_a: assert property (req.wr && req.addr == ADDR_DEF_DIR_LO
                                    |=> st.def_dir[7:0] == $past(req.wdata)) // [RL4]
    else $error("Default direction write lost");

  def_cfg_write_a: assert property (req.wr && req.addr == ADDR_DEF_CFG
                                    |=> st.def_cfg == $past(req.wdata)) // [RL6]
    else $error("Default configuration write lost");

  refresh_cfg_a: assert property (refresh |=> {st.drive_strength_select, st.drive_type, st.invert}
                                  == $past({st.def_cfg, st.def_inv_lo})) // [RL15]
    else $error("Refresh did not reload configuration");

  // A same-cycle write must lose, or a refresh could leave a half-updated port
  refresh_wins_a: assert property (refresh && req.wr && req.addr == ADDR_OUT_LO
                                   |=> st.out_value == $past(st.def_out)) // [RL15]
    else $error("Write beat refresh");

  out_hi_read_a: assert property (req.rd && req.addr == ADDR_OUT_HI |=> resp.rdata[7:4] == 4'h0) // [RL18]
    else $error("Upper output value bits not zero");

  dir_hi_read_a: assert property (req.rd && req.addr == ADDR_DIR_HI |=> resp.rdata[7:4] == 4'h0) // [RL18]
    else $error("Upper direction bits not zero");

  def_hi_read_a: assert property (req.rd && req.addr == ADDR_DEF_OUT_HI |=> resp.rdata[7:4] == 4'h0) // [RL16]
    else $error("Upper default output bits not zero");

  out_lo_read_a: assert property (req.rd && req.addr == ADDR_OUT_LO
                                  |=> resp.rdata == $past(st.out_value[7:0])) // [RL1]
    else $error("Output value readback wrong");

  dir_lo_read_a: assert property (req.rd && req.addr == ADDR_DIR_LO
                                  |=> resp.rdata == $past(st.direction[7:0])) // [RL3]
    else $error("Direction readback wrong");

  inv_read_a: assert property (req.rd && req.addr == ADDR_INV_LO
                               |=> resp.rdata == $past(st.invert[7:0])) // [RL5]
    else $error("Inversion readback wrong");

  cfg_read_a: assert property (req.rd && req.addr == ADDR_CFG
                               |=> resp.rdata == $past({st.drive_strength_select, st.drive_type,
                                                        st.invert[11:8]})) // [RL6]
    else $error("Configuration readback wrong");

  pin_high_xor_a: assert property (req.rd && req.addr == ADDR_PIN_HI && st.drive.oe[11:8] == 4'h0
                                   |=> resp.rdata[3:0] == $past(st.pin_sample[11:8] ^ st.invert[11:8])) // [RL12]
    else $error("Upper pin state is not pin XOR inversion");

  driven_readback_a: assert property (req.rd && req.addr == ADDR_PIN_LO && st.drive.oe[7:0] == 8'hFF
                                      |=> resp.rdata == $past(st.drive.level[7:0] ^ st.invert[7:0])) // [RL14]
    else $error("Driven line readback wrong");

  pin_high_ro_a: assert property (req.wr && req.addr == ADDR_PIN_HI && !refresh
                                  |=> $stable(st.out_value) && $stable(st.direction) && $stable(st.invert)) // [RL9]
    else $error("Write to upper pin state changed settings");

  open_drain0_a: assert property (!st.drive_strength_select && st.drive_type[0] |=> st.drive.level[3:0] == 4'h0) // [RL7]
    else $error("Open drain group 0 driven high");

  open_drain2_a: assert property (!st.drive_strength_select && st.drive_type[2] |=> st.drive.level[11:8] == 4'h0) // [RL7]
    else $error("Open drain group 2 driven high");

  od_release_a: assert property (!st.drive_strength_select && st.drive_type[1]
                                 |=> (st.drive.oe[7:4] & $past(st.out_value[7:4])) == 4'h0) // [RL7]
    else $error("Open drain high line not released");

  simul_switch_a: assert property (!st.drive_strength_select
                                   |=> st.drive.oe == $past(target_oe) && st.drive.level == $past(target_level)) // [RL8]
    else $error("Simultaneous mode did not switch all lines");

  // Sequential mode must not stall short of the target
  seq_progress_a: assert property (st.drive_strength_select
                                   && (st.drive.oe != target_oe || st.drive.level != target_level)
                                   |=> st.drive != $past(st.drive)) // [RL8]
    else $error("Sequential mode stalled");

endmodule
